//--- timer_cfg.svh
// holds the register map, field positions and reset values of the time base
// assumes inclusion by bare name from every file that needs a constant
//
// Contract
// R1: 16-bit up-counter with auto-reload value
// R2: count, prescale, reload accessible while running
// R3: reload accesses reach preload copy only
// R4: reload shadow follows preload unless preload selected
// R5: overflow raises update unless update inhibited
// R6: software may force an update event
// R7: counter advances on gated prescaler ticks
// R8: counting starts one cycle after run set
// R9: 16-bit prescaler divides by 1 to 65536
// R10: prescale value buffered, applied at update
// R11: divide by value plus one, restart on update
// R12: count zero to reload, then wrap, overflow
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TB_OFS_CTRL 8'h00
`define TB_OFS_STATUS 8'h04
`define TB_OFS_MASK 8'h08
`define TB_OFS_EVGEN 8'h0c
`define TB_OFS_COUNT 8'h10
`define TB_OFS_PRESCALE 8'h14
`define TB_OFS_RELOAD 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TB_CTRL_RUN 0
`define TB_CTRL_INHIBIT 1
`define TB_CTRL_PRELOAD 2
`define TB_ST_UPDATE 0
`define TB_ST_OVERFLOW 1
`define TB_EV_UPDATE 0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TB_RST_CTRL 3'h0
`define TB_RST_STATUS 2'h0
`define TB_RST_MASK 2'h0
`define TB_RST_COUNT 16'h0000
`define TB_RST_PRESCALE 16'h0000
`define TB_RST_RELOAD 16'hffff

`endif

//--- timer_pkg.sv
// holds the shared types of the time base
// assumes nothing beyond a systemverilog compiler
package timer_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} bus_phase_t;

	typedef logic [15:0] word16_t;

endpackage

//--- timebase_if.sv
// holds the tick and update signals shared by prescaler, counter and control
// assumes one clock domain for all three parties
`timescale 1ns/100ps
interface timebase_if;
	logic counter_tick;
	logic update_pulse;
	logic overflow;

	modport psc_mp (input update_pulse, output counter_tick);
	modport cnt_mp (input counter_tick, input update_pulse, output overflow);
	modport ctl_mp (input counter_tick, input overflow, output update_pulse);
endinterface

//--- tb_prescaler.sv
// holds the buffered 16-bit prescaler that makes the counter ticks
// assumes update pulses come from the control block in the same clock
`timescale 1ns/100ps
module tb_prescaler #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic count_run_bit,
	input wire logic [WIDTH-1:0] prescale_value,
	timebase_if.psc_mp tb
);
	logic [WIDTH-1:0] active_q;
	logic [WIDTH-1:0] div_q;
	logic wrap;

	// ---------------------------------------------------------------
	// divider
	// ---------------------------------------------------------------
	// R11 divide by value plus one
	assign wrap = (div_q == active_q);
	// R7 ticks gated by run
	assign tb.counter_tick = count_run_bit & wrap;

	// R10 ratio loaded at update
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_q <= '0;
		end else if (tb.update_pulse) begin
			active_q <= prescale_value;
		end
	end

	// R9 16-bit prescaler counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
		end else if (tb.update_pulse) begin
			// R11 restart on update
			div_q <= '0;
		end else if (count_run_bit) begin
			div_q <= wrap ? '0 : div_q + 1'b1;
		end
	end
endmodule // tb_prescaler

//--- tb_counter.sv
// holds the 16-bit up-counter and the shadowed reload value
// assumes writes and update pulses are single-cycle strobes
`timescale 1ns/100ps
`include "timer_cfg.svh"
module tb_counter #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic reload_preload_select,
	input wire logic [WIDTH-1:0] reload_value,
	input wire logic count_wr,
	input wire logic [WIDTH-1:0] count_wdata,
	output logic [WIDTH-1:0] count_value,
	timebase_if.cnt_mp tb
);
	logic [WIDTH-1:0] shadow_q;
	logic [WIDTH-1:0] count_q;

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	// R12 wrap after reaching reload
	assign tb.overflow = tb.counter_tick & (count_q == shadow_q);
	assign count_value = count_q;

	// R4 shadow follows or waits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shadow_q <= `TB_RST_RELOAD;
		end else if (!reload_preload_select || tb.update_pulse) begin
			shadow_q <= reload_value;
		end
	end

	// R1 16-bit up-counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= `TB_RST_COUNT;
		end else if (count_wr) begin
			// R2 writable while running
			count_q <= count_wdata;
		end else if (tb.update_pulse || tb.overflow) begin
			count_q <= '0;
		end else if (tb.counter_tick) begin
			// R7 advance on tick only
			count_q <= count_q + 1'b1;
		end
	end
endmodule // tb_counter

//--- timer_time_base_unit.sv
// holds the time-base top: ahb-lite register slave, update control, interrupt
// assumes one ahb-lite master, single word transfers, synchronous inputs
// a read right after a write to the same word sees the new value
`timescale 1ns/100ps
`include "timer_cfg.svh"
module timer_time_base_unit #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	output logic update_pulse
);
	timebase_if tb ();

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic count_run_bit_q;
	logic update_inhibit_bit_q;
	logic reload_preload_select_q;
	logic [1:0] status_q;
	logic [1:0] status_d;
	logic [1:0] mask_q;
	logic [WIDTH-1:0] prescale_value_q;
	logic [WIDTH-1:0] reload_value_q;
	logic [WIDTH-1:0] count_value;
	logic [31:0] hrdata_q;
	logic [31:0] rd_word;
	logic run_next;
	logic inhibit_next;
	logic preload_next;
	logic [1:0] mask_next;
	logic [WIDTH-1:0] prescale_next;
	logic [WIDTH-1:0] reload_next;
	logic [WIDTH-1:0] count_next;
	logic [1:0] pending;

	// ---------------------------------------------------------------
	// bus phase tracking
	// ---------------------------------------------------------------
	timer_pkg::bus_phase_t phase_q;
	logic addr_ok;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic wr_go;
	logic sw_update;
	logic count_wr;
	logic word_size;
	logic rd_go;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;
	logic wr_evgen;
	logic wr_prescale;
	logic wr_reload;

	// only word-sized accesses are honoured; others complete but do nothing
	assign word_size = (hsize == 3'h2);
	assign addr_ok = hsel & hready & htrans[1] & word_size;
	// read word is captured at the address phase edge
	assign rd_go = addr_ok & ~hwrite;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= timer_pkg::BUS_IDLE;
		end else if (hready) begin
			// either phase may be followed by a new address phase: transfers pipeline
			unique case (phase_q)
				timer_pkg::BUS_IDLE: begin
					phase_q <= addr_ok ? timer_pkg::BUS_DATA : timer_pkg::BUS_IDLE;
				end
				timer_pkg::BUS_DATA: begin
					phase_q <= addr_ok ? timer_pkg::BUS_DATA : timer_pkg::BUS_IDLE;
				end
				// a stray code falls back to idle
				default: begin
					phase_q <= timer_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
		end else if (hready) begin
			wr_pend_q <= addr_ok & hwrite;
		end
	end

	// address kept for the data phase, when hwdata arrives
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_addr_q <= 8'h00;
		end else if (hready) begin
			wr_addr_q <= haddr[7:0];
		end
	end

	// zero-wait slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wr_go = wr_pend_q & (phase_q == timer_pkg::BUS_DATA);

	// ---------------------------------------------------------------
	// write strobes
	// ---------------------------------------------------------------
	// one strobe per register, so each process below owns one concern
	assign wr_ctrl = wr_go & (wr_addr_q == `TB_OFS_CTRL);
	assign wr_status = wr_go & (wr_addr_q == `TB_OFS_STATUS);
	assign wr_mask = wr_go & (wr_addr_q == `TB_OFS_MASK);
	assign wr_evgen = wr_go & (wr_addr_q == `TB_OFS_EVGEN);
	assign wr_prescale = wr_go & (wr_addr_q == `TB_OFS_PRESCALE);
	assign wr_reload = wr_go & (wr_addr_q == `TB_OFS_RELOAD);
	assign count_wr = wr_go & (wr_addr_q == `TB_OFS_COUNT);

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	// R8 run flop delays start one cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_run_bit_q <= 1'(`TB_RST_CTRL >> `TB_CTRL_RUN);
		end else if (wr_ctrl) begin
			count_run_bit_q <= hwdata[`TB_CTRL_RUN];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			update_inhibit_bit_q <= 1'(`TB_RST_CTRL >> `TB_CTRL_INHIBIT);
		end else if (wr_ctrl) begin
			update_inhibit_bit_q <= hwdata[`TB_CTRL_INHIBIT];
		end
	end

	// preload select only steers the shadow copy, never the counter itself
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reload_preload_select_q <= 1'(`TB_RST_CTRL >> `TB_CTRL_PRELOAD);
		end else if (wr_ctrl) begin
			reload_preload_select_q <= hwdata[`TB_CTRL_PRELOAD];
		end
	end

	// ---------------------------------------------------------------
	// value registers
	// ---------------------------------------------------------------
	// R2 prescale writable any time
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prescale_value_q <= `TB_RST_PRESCALE;
		end else if (wr_prescale) begin
			prescale_value_q <= hwdata[WIDTH-1:0];
		end
	end

	// R3 writes land in preload copy
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reload_value_q <= `TB_RST_RELOAD;
		end else if (wr_reload) begin
			reload_value_q <= hwdata[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= `TB_RST_MASK;
		end else if (wr_mask) begin
			mask_q <= hwdata[1:0];
		end
	end

	// R6 software forced update
	assign sw_update = wr_evgen & hwdata[`TB_EV_UPDATE];

	// ---------------------------------------------------------------
	// update generation
	// ---------------------------------------------------------------
	// R5 overflow update unless inhibited
	assign tb.update_pulse = (tb.overflow & ~update_inhibit_bit_q) | sw_update;
	assign update_pulse = tb.update_pulse;

	// ---------------------------------------------------------------
	// status and interrupt
	// ---------------------------------------------------------------
	// set wins over a same-cycle write-one clear
	always_comb begin
		status_d = status_q;
		if (wr_status) begin
			status_d = status_q & ~hwdata[1:0];
		end
		if (tb.update_pulse) begin
			status_d[`TB_ST_UPDATE] = 1'b1;
		end
		if (tb.overflow) begin
			status_d[`TB_ST_OVERFLOW] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= `TB_RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	// registered so the pin never glitches while status and mask settle
	// status_d is used so irq rises at the same edge as the status bit
	assign pending = status_d & mask_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |pending;
		end
	end

	// ---------------------------------------------------------------
	// values after this edge
	// ---------------------------------------------------------------
	// a read taken in the data phase of a write must see the new word;
	// without this a back-to-back read would return the stale value
	assign run_next = wr_ctrl ? hwdata[`TB_CTRL_RUN] : count_run_bit_q;
	assign inhibit_next = wr_ctrl ? hwdata[`TB_CTRL_INHIBIT] : update_inhibit_bit_q;
	assign preload_next = wr_ctrl ? hwdata[`TB_CTRL_PRELOAD] : reload_preload_select_q;
	assign mask_next = wr_mask ? hwdata[1:0] : mask_q;
	assign prescale_next = wr_prescale ? hwdata[WIDTH-1:0] : prescale_value_q;
	assign reload_next = wr_reload ? hwdata[WIDTH-1:0] : reload_value_q;
	// live count lags a cycle anyway; only a software write is forwarded
	assign count_next = count_wr ? hwdata[WIDTH-1:0] : count_value;

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	// R2 reads show live values
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[7:0])
			`TB_OFS_CTRL: begin
				rd_word[`TB_CTRL_RUN] = run_next;
				rd_word[`TB_CTRL_INHIBIT] = inhibit_next;
				rd_word[`TB_CTRL_PRELOAD] = preload_next;
			end
			`TB_OFS_STATUS: rd_word[1:0] = status_d;
			`TB_OFS_MASK: rd_word[1:0] = mask_next;
			`TB_OFS_COUNT: rd_word[WIDTH-1:0] = count_next;
			`TB_OFS_PRESCALE: rd_word[WIDTH-1:0] = prescale_next;
			// R3 reads return preload copy
			`TB_OFS_RELOAD: rd_word[WIDTH-1:0] = reload_next;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// sampled in the address phase: a write just before is already visible
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			hrdata_q <= rd_word;
		end
	end
	assign hrdata = hrdata_q;

	// ---------------------------------------------------------------
	// datapath instances
	// ---------------------------------------------------------------
	tb_prescaler #(
		.WIDTH(WIDTH)
	) u_psc (
		.clk(clk),
		.resetn(resetn),
		.count_run_bit(count_run_bit_q),
		.prescale_value(prescale_value_q),
		.tb(tb.psc_mp)
	);

	tb_counter #(
		.WIDTH(WIDTH)
	) u_cnt (
		.clk(clk),
		.resetn(resetn),
		.reload_preload_select(reload_preload_select_q),
		.reload_value(reload_value_q),
		.count_wr(count_wr),
		.count_wdata(hwdata[WIDTH-1:0]),
		.count_value(count_value),
		.tb(tb.cnt_mp)
	);
endmodule // timer_time_base_unit

//--- tbu_properties.sv
// port checker of the time-base top
// assumes binding onto timer_time_base_unit, word transfers only
`timescale 1ns/100ps
`include "timer_cfg.svh"
module tbu_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq,
	input wire logic update_pulse
);
	logic go;
	logic wr_q;
	logic [7:0] a_q;
	logic [15:0] rl_q;
	logic [15:0] ps_q;
	logic [1:0] mk_q;
	logic ru_q;
	assign go = hsel && hready && htrans[1] && hsize == 3'h2;
	// ----
	// copies of written registers
	// ----
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= 1'b0;
			a_q <= 8'h00;
			rl_q <= 16'hffff;
			ps_q <= 16'h0000;
			mk_q <= 2'h0;
			ru_q <= 1'b0;
		end else begin
			wr_q <= go && hwrite;
			a_q <= haddr[7:0];
			if (wr_q && a_q == `TB_OFS_RELOAD) rl_q <= hwdata[15:0];
			if (wr_q && a_q == `TB_OFS_PRESCALE) ps_q <= hwdata[15:0];
			if (wr_q && a_q == `TB_OFS_MASK) mk_q <= hwdata[1:0];
			if (wr_q && a_q == `TB_OFS_CTRL) ru_q <= hwdata[0];
		end
	end
	sequence rd_at(logic [7:0] a);
		go && !hwrite && haddr[7:0] == a;
	endsequence
	sequence sw_upd;
		go && hwrite && haddr[7:0] == `TB_OFS_EVGEN ##1 hwdata[0];
	endsequence
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	AST_READY: assert property (hreadyout)
		else $error("slave stalled");
	AST_OKAY: assert property (!hresp)
		else $error("error response");
	AST_UNMAPPED: assert property (rd_at(8'h1c) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RELOAD_RB: assert property (rd_at(`TB_OFS_RELOAD) |=> hrdata == {16'h0, rl_q})
		else $error("reload readback differs");
	AST_PSC_RB: assert property (rd_at(`TB_OFS_PRESCALE) |=> hrdata == {16'h0, ps_q})
		else $error("prescale readback differs");
	AST_SW_UPD: assert property (sw_upd |-> ##[0:1] update_pulse)
		else $error("software update missing");
	AST_MASKED: assert property (mk_q == 2'h0 && $past(mk_q) == 2'h0 |-> !irq)
		else $error("irq while all masked");
	AST_QUIET: assert property ($rose(resetn) |-> !irq && !update_pulse)
		else $error("activity right after reset");
	AST_GATED: assert property (!ru_q && !(wr_q && a_q == `TB_OFS_EVGEN) |-> !update_pulse)
		else $error("update while stopped");
endmodule // tbu_props
bind timer_time_base_unit tbu_props tbu_props_i (.clk(clk), .resetn(resetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.update_pulse(update_pulse));

//--- timer_time_base_unit_tb.sv
// self-checking bench of the time-base top
// assumes it is the only slave, hready looped back from hreadyout
`timescale 1ns/100ps
`include "timer_cfg.svh"
module timer_time_base_unit_tb;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic update_pulse;
	logic [31:0] rd;
	int fails = 0;
	int samples_checked = 0;
	int gap = 0;
	int last_gap = 0;
	int n;
	row_t rows [14] = '{'{`TB_OFS_CTRL, 1'b0, 32'h0, 32'h0},
		'{`TB_OFS_STATUS, 1'b0, 32'h0, 32'h0}, '{`TB_OFS_MASK, 1'b0, 32'h0, 32'h0},
		'{`TB_OFS_COUNT, 1'b0, 32'h0, 32'h0}, '{`TB_OFS_PRESCALE, 1'b0, 32'h0, 32'h0},
		'{`TB_OFS_RELOAD, 1'b0, 32'h0, 32'hffff}, '{8'h1c, 1'b0, 32'h0, 32'h0},
		'{`TB_OFS_CTRL, 1'b1, 32'h6, 32'h6}, '{`TB_OFS_MASK, 1'b1, 32'hffffffff, 32'h3},
		'{`TB_OFS_COUNT, 1'b1, 32'h1234, 32'h1234},
		'{`TB_OFS_PRESCALE, 1'b1, 32'hffffffff, 32'hffff},
		'{`TB_OFS_RELOAD, 1'b1, 32'h12345, 32'h2345},
		'{`TB_OFS_EVGEN, 1'b1, 32'h1, 32'h0}, '{8'h1c, 1'b1, 32'hffffffff, 32'h0}};
	timer_time_base_unit timer_time_base_unit_i (.clk(clk), .resetn(resetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq(irq), .update_pulse(update_pulse));
	always #25 clk = ~clk;
	// gap between update pulses, sampled mid-cycle to dodge edge races
	always @(negedge clk) begin
		gap++;
		if (update_pulse === 1'b1) begin
			last_gap = gap;
			gap = 0;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wait_upd(output int k);
		int t;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (update_pulse !== 1'b1 && t < 400);
		if (update_pulse !== 1'b1) fails++;
		#1;
		k = last_gap;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// whole run is well under 2000 cycles
	initial begin
		#(20000 * 50);
		fails++;
		give_verdict;
	end
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d, rd);
			xfer(1'b0, rows[i].a, 32'h0, rd);
			chk("register", rd, rows[i].e);
		end
		$display("test registers done");
		xfer(1'b1, `TB_OFS_CTRL, 32'h0, rd);
		xfer(1'b1, `TB_OFS_PRESCALE, 32'h2, rd);
		xfer(1'b1, `TB_OFS_RELOAD, 32'h3, rd);
		xfer(1'b1, `TB_OFS_EVGEN, 32'h1, rd);
		xfer(1'b1, `TB_OFS_CTRL, 32'h1, rd);
		gap = 0;
		// (reload 3 + 1) ticks of (prescale 2 + 1) cycles
		wait_upd(n);
		chk("start", n, 12);
		wait_upd(n);
		chk("period", n, 12);
		xfer(1'b1, `TB_OFS_CTRL, 32'h5, rd);
		xfer(1'b1, `TB_OFS_RELOAD, 32'h5, rd);
		wait_upd(n);
		chk("held reload", n, 12);
		wait_upd(n);
		chk("new reload", n, 18);
		xfer(1'b1, `TB_OFS_CTRL, 32'h1, rd);
		xfer(1'b1, `TB_OFS_PRESCALE, 32'h0, rd);
		wait_upd(n);
		chk("held prescale", n, 18);
		wait_upd(n);
		chk("new prescale", n, 6);
		xfer(1'b1, `TB_OFS_RELOAD, 32'h9, rd);
		wait_upd(n);
		chk("live reload", n, 10);
		$display("test timing done");
		xfer(1'b1, `TB_OFS_CTRL, 32'h3, rd);
		xfer(1'b1, `TB_OFS_MASK, 32'h1, rd);
		xfer(1'b1, `TB_OFS_STATUS, 32'h3, rd);
		n = 0;
		repeat (40) begin
			@(negedge clk);
			if (update_pulse === 1'b1) n++;
		end
		chk("inhibited", n, 0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		xfer(1'b0, `TB_OFS_STATUS, 32'h0, rd);
		chk("status", rd, 32'h2);
		hsize <= 3'h0;
		xfer(1'b1, `TB_OFS_MASK, 32'h0, rd);
		hsize <= 3'h2;
		xfer(1'b0, `TB_OFS_MASK, 32'h0, rd);
		chk("sized write", rd, 32'h1);
		xfer(1'b1, `TB_OFS_CTRL, 32'h0, rd);
		xfer(1'b1, `TB_OFS_COUNT, 32'h7, rd);
		xfer(1'b1, `TB_OFS_EVGEN, 32'h1, rd);
		xfer(1'b0, `TB_OFS_COUNT, 32'h0, rd);
		chk("cleared count", rd, 32'h0);
		chk("irq raised", {31'h0, irq}, 32'h1);
		$display("test events done");
		give_verdict;
	end
endmodule // timer_time_base_unit_tb
